/* src/rsc_reset_ctrl.sv */
/*
 * System reset controller: merges every reset source into one system
 * reset, holds it for a fixed count after the last source goes away,
 * and supplies the source-dependent reset values.
 * Assumes the watchdog, calendar and debugger inputs are synchronous to
 * REF_CLK; pin and supply detector inputs may be asynchronous.
 */
// Summary of operation
// - Power-on, brown-out, reset pin or debug reset command put the system in reset.
// - A watchdog time-out resets the system only when its reset option is enabled.
// - A calendar alarm resets the system only while the CPU is in deep sleep.
// - The system stays in reset for 257 clock cycles of the duration timer.
// - The duration timer starts on the first edge after all sources are gone.
// - While in reset, all reset-affected registers are held at their defaults.
// - Reset clears the program counter to zero.
// - Reset puts every general-purpose port pin into input mode.
// - No code runs during reset, including the whole duration count.
// - Watchdog control loads 00h after a pin reset and 20h after a time-out.
// - Calendar control loads x0xxxx00b after pin or watchdog, x0xxxx10b after alarm.
// - The power-on detector request is a live source, then the full count runs.
// - A reset that ends deep sleep also runs the full count for oscillator start.

module rsc_reset_ctrl #(
  parameter int unsigned HOLD = rsc_pkg::HOLD_CYCLES
) (
  input wire logic REF_CLK, // system clock, 100 MHz
  input wire logic NRST, // async reset, active low
  input wire logic POWER_ON_DET, // power-on detector request, async
  input wire logic BROWNOUT_DET, // supply_brownout_detect request, async
  input wire logic EXT_RESET_N, // external reset pin, active low, async
  input wire logic WDT_TIMEOUT, // watchdog_unit time-out event
  input wire logic WDT_RESET_EN, // watchdog configured to reset
  input wire logic RTC_ALARM, // calendar alarm event
  input wire logic SLEEP_ACTIVE, // deep_sleep_instruction mode active
  input wire logic DBG_RESET, // debug reset command
  output logic SYS_RESET, // system reset, active high
  output logic CPU_RUN_EN, // program execution allowed
  output logic PC_LOAD, // load program_counter with reset value
  output logic [23:0] PC_VALUE, // program_counter reset value
  output logic PORT_FORCE_INPUT, // port pins forced to input
  output logic [7:0] WDT_CTL_INIT, // watchdog control reset value
  output logic [7:0] RTC_CTL_INIT, // calendar control reset value
  output logic [2:0] RESET_CAUSE // source of latest reset
);
  localparam logic [rsc_pkg::CNT_W-1:0] HOLD_N =
    rsc_pkg::CNT_W'(HOLD);

  // refuse a hold count the duration counter cannot reach
  if (HOLD < 1 || HOLD >= (1 << rsc_pkg::CNT_W)) begin : g_bad_hold
    $error("HOLD out of range for the duration counter");
  end

  typedef struct packed {
    rsc_pkg::rsc_state_e st;
    logic [rsc_pkg::CNT_W-1:0] cnt;
    rsc_pkg::rsc_cause_e cause;
    logic sys_rst;
    logic run_en;
    logic [23:0] pc;
    logic [7:0] wdt_init;
    logic [7:0] rtc_init;
  } rsc_s;

  rsc_s r;
  rsc_s next_r;

  // ------------------------------------------------------------
  // source conditioning
  // ------------------------------------------------------------
  logic [2:0] async_req;
  logic [2:0] sync_req;
  logic wdt_req;
  logic rtc_req;
  logic any_req;

  assign async_req = {~EXT_RESET_N, BROWNOUT_DET, POWER_ON_DET};

  rsc_sync #(.WIDTH(3)) u_sync (
    .clk(REF_CLK),
    .rst_n(NRST),
    .din(async_req),
    .dout(sync_req)
  );

  assign wdt_req = WDT_TIMEOUT & WDT_RESET_EN;
  assign rtc_req = RTC_ALARM & SLEEP_ACTIVE;
  assign any_req = |sync_req | wdt_req | rtc_req | DBG_RESET;

  function automatic rsc_pkg::rsc_cause_e cause_of(
    input logic [2:0] s, input logic w, input logic a);
    if (s[0]) return rsc_pkg::CAUSE_POWER_ON;
    else if (s[1]) return rsc_pkg::CAUSE_BROWNOUT;
    else if (s[2]) return rsc_pkg::CAUSE_PIN;
    else if (w) return rsc_pkg::CAUSE_WATCHDOG;
    else if (a) return rsc_pkg::CAUSE_ALARM;
    else return rsc_pkg::CAUSE_DEBUG;
  endfunction

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (any_req) begin
      next_r.cause = cause_of(sync_req, wdt_req, rtc_req);
    end
    case (r.st)
      rsc_pkg::ST_HOLD: begin
        if (!any_req) begin
          next_r.st = rsc_pkg::ST_COUNT;
          next_r.cnt = rsc_pkg::CNT_W'(1);
        end
      end
      rsc_pkg::ST_COUNT: begin
        if (any_req) begin
          next_r.st = rsc_pkg::ST_HOLD;
          next_r.cnt = '0;
        end else if (r.cnt == HOLD_N) begin
          next_r.st = rsc_pkg::ST_RUN;
          next_r.cnt = '0;
        end else begin
          next_r.cnt = r.cnt + rsc_pkg::CNT_W'(1);
        end
      end
      default: begin
        if (any_req) begin
          next_r.st = rsc_pkg::ST_HOLD;
          next_r.cnt = '0;
        end
      end
    endcase
    next_r.sys_rst = (next_r.st != rsc_pkg::ST_RUN);
    next_r.run_en = (next_r.st == rsc_pkg::ST_RUN);
    next_r.pc = rsc_pkg::PC_RESET_VALUE;
    if (next_r.cause == rsc_pkg::CAUSE_WATCHDOG)
      next_r.wdt_init = rsc_pkg::WDT_CTL_TIMEOUT_VALUE;
    else
      next_r.wdt_init = rsc_pkg::WDT_CTL_PIN_VALUE;
    if (next_r.cause == rsc_pkg::CAUSE_ALARM)
      next_r.rtc_init = rsc_pkg::RTC_CTL_ALARM_VALUE;
    else
      next_r.rtc_init = rsc_pkg::RTC_CTL_PIN_VALUE;
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      r.st <= rsc_pkg::ST_HOLD;
      r.cnt <= '0;
      r.cause <= rsc_pkg::CAUSE_POWER_ON;
      r.sys_rst <= 1'b1;
      r.run_en <= 1'b0;
      r.pc <= rsc_pkg::PC_RESET_VALUE;
      r.wdt_init <= rsc_pkg::WDT_CTL_PIN_VALUE;
      r.rtc_init <= rsc_pkg::RTC_CTL_PIN_VALUE;
    end else begin
      r <= next_r;
    end
  end

  assign SYS_RESET = r.sys_rst;
  assign CPU_RUN_EN = r.run_en;
  assign PC_LOAD = r.sys_rst;
  assign PC_VALUE = r.pc;
  assign PORT_FORCE_INPUT = r.sys_rst;
  assign WDT_CTL_INIT = r.wdt_init;
  assign RTC_CTL_INIT = r.rtc_init;
  assign RESET_CAUSE = r.cause;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [rsc_pkg::CNT_W-1:0] quiet;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST)
      quiet <= '0;
    else if (any_req)
      quiet <= '0;
    else if (quiet != '1)
      quiet <= quiet + rsc_pkg::CNT_W'(1);
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_src_enters_reset: assert property (
    (DBG_RESET || sync_req != 3'b000) |=> SYS_RESET)
    else $error("source active but no system reset");
  a_wdt_gated: assert property (
    (r.st == rsc_pkg::ST_RUN && WDT_TIMEOUT && !WDT_RESET_EN &&
     !rtc_req && !DBG_RESET && sync_req == 3'b000) |=> !SYS_RESET)
    else $error("ungated watchdog time-out caused reset");
  a_alarm_gated: assert property (
    (r.st == rsc_pkg::ST_RUN && RTC_ALARM && !SLEEP_ACTIVE &&
     !wdt_req && !DBG_RESET && sync_req == 3'b000) |=> !SYS_RESET)
    else $error("alarm outside sleep caused reset");
  a_hold_length: assert property (
    $fell(SYS_RESET) |-> $past(quiet) == HOLD_N)
    else $error("reset released after wrong count");
  a_count_start: assert property (
    (r.st == rsc_pkg::ST_HOLD && !any_req) |=>
      (r.st == rsc_pkg::ST_COUNT && r.cnt == 1))
    else $error("duration timer did not start");
  a_no_run_reset: assert property (
    SYS_RESET |-> !CPU_RUN_EN && PC_LOAD && PORT_FORCE_INPUT)
    else $error("execution enabled during reset");
  a_pc_zero: assert property (
    PC_LOAD |-> PC_VALUE == rsc_pkg::PC_RESET_VALUE)
    else $error("program counter reset value not zero");
  a_wdt_value: assert property (
    (SYS_RESET && RESET_CAUSE == rsc_pkg::CAUSE_WATCHDOG) |->
      WDT_CTL_INIT == rsc_pkg::WDT_CTL_TIMEOUT_VALUE)
    else $error("watchdog reset value wrong");
  a_rtc_value: assert property (
    (RESET_CAUSE == rsc_pkg::CAUSE_PIN) |->
      (RTC_CTL_INIT & rsc_pkg::RTC_CTL_DEFINED_MASK) == 8'h00)
    else $error("calendar reset value wrong after pin reset");
  a_cause_latch: assert property (
    (sync_req[0]) |=> RESET_CAUSE == rsc_pkg::CAUSE_POWER_ON)
    else $error("power-on cause not recorded");

  c_pin_reset: cover property ($fell(SYS_RESET) && RESET_CAUSE ==
    rsc_pkg::CAUSE_PIN);
  c_wdt_reset: cover property ($fell(SYS_RESET) && RESET_CAUSE ==
    rsc_pkg::CAUSE_WATCHDOG);
  c_alarm_reset: cover property ($fell(SYS_RESET) && RESET_CAUSE ==
    rsc_pkg::CAUSE_ALARM);
  c_restart: cover property (r.st == rsc_pkg::ST_COUNT && any_req);
endmodule

/* src/rsc_sync.sv */
/*
 * Shared constants of the system reset controller and its two-flop
 * synchroniser for asynchronous reset requests.
 * Assumes one free-running system clock and an active-low async reset.
 */

// ------------------------------------------------------------
// constants
// ------------------------------------------------------------
package rsc_pkg;
  localparam int unsigned HOLD_CYCLES = 257;
  localparam int unsigned CNT_W = 9;
  localparam logic [23:0] PC_RESET_VALUE = 24'h00_0000;
  localparam logic [7:0] WDT_CTL_PIN_VALUE = 8'h00;
  localparam logic [7:0] WDT_CTL_TIMEOUT_VALUE = 8'h20;
  localparam logic [7:0] RTC_CTL_PIN_VALUE = 8'h00;
  localparam logic [7:0] RTC_CTL_ALARM_VALUE = 8'h02;
  // only bits 6, 1 and 0 of the calendar value are defined
  localparam logic [7:0] RTC_CTL_DEFINED_MASK = 8'h43;
  localparam logic SYNC_RESET_LEVEL = 1'b1;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON,
    CAUSE_BROWNOUT,
    CAUSE_PIN,
    CAUSE_WATCHDOG,
    CAUSE_ALARM,
    CAUSE_DEBUG
  } rsc_cause_e;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_COUNT,
    ST_RUN
  } rsc_state_e;
endpackage

// ------------------------------------------------------------
// two-flop synchroniser
// ------------------------------------------------------------
module rsc_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] din, // asynchronous levels
  output logic [WIDTH-1:0] dout // synchronised levels
);
  logic [WIDTH-1:0] meta;

  // reset to the asserted level so a request is seen during reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{rsc_pkg::SYNC_RESET_LEVEL}};
      dout <= {WIDTH{rsc_pkg::SYNC_RESET_LEVEL}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* test/rsc_src_model.sv */
/*
 * Model of the reset sources around the controller: supply detectors,
 * reset pin, watchdog, calendar alarm and debugger.
 * Assumes kind and on change just after a rising clock edge.
 */
module rsc_src_model (
  input wire logic [2:0] kind, // source, 6/7 are unqualified
  input wire logic on, // raise the source
  output logic por, // power-on request
  output logic bod, // brown-out request
  output logic pin_n, // reset pin, active low
  output logic wdt_to, // watchdog time-out
  output logic wdt_en, // watchdog reset option
  output logic alarm, // calendar alarm
  output logic sleep, // cpu in deep sleep
  output logic dbg // debug reset command
);
  always_comb begin
    por = on && kind == 3'h0;
    bod = on && kind == 3'h1;
    pin_n = !(on && kind == 3'h2);
    wdt_to = on && (kind == 3'h3 || kind == 3'h6);
    wdt_en = kind == 3'h3;
    alarm = on && (kind == 3'h4 || kind == 3'h7);
    sleep = kind == 3'h4;
    dbg = on && kind == 3'h5;
  end
endmodule

/* test/testbench.sv */
/*
 * Self-checking bench of the system reset controller.
 * Assumes the hold count is shortened through the HOLD parameter.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] kind = 3'h5;
  logic on = 1'b0;
  logic por, bod, pin_n, wdt_to, wdt_en, alarm, sleep, dbg;
  logic sys_rst, run_en, pc_load, port_in;
  logic [23:0] pc_val;
  logic [7:0] wdt_init, rtc_init;
  logic [2:0] cause;
  int bad_count = 0;
  int check_count = 0;
  int hi_cnt = 0;
  int cyc = 0;

  always #5 clk = !clk;

  rsc_src_model u_src (.kind(kind), .on(on), .por(por), .bod(bod),
    .pin_n(pin_n), .wdt_to(wdt_to), .wdt_en(wdt_en), .alarm(alarm),
    .sleep(sleep), .dbg(dbg));

  rsc_reset_ctrl #(.HOLD(HOLD)) u_dut (.REF_CLK(clk), .NRST(nrst),
    .POWER_ON_DET(por), .BROWNOUT_DET(bod), .EXT_RESET_N(pin_n),
    .WDT_TIMEOUT(wdt_to), .WDT_RESET_EN(wdt_en), .RTC_ALARM(alarm),
    .SLEEP_ACTIVE(sleep), .DBG_RESET(dbg), .SYS_RESET(sys_rst),
    .CPU_RUN_EN(run_en), .PC_LOAD(pc_load), .PC_VALUE(pc_val),
    .PORT_FORCE_INPUT(port_in), .WDT_CTL_INIT(wdt_init),
    .RTC_CTL_INIT(rtc_init), .RESET_CAUSE(cause));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // reset length and side outputs, sampled mid-cycle
  always @(negedge clk) begin
    if (nrst && sys_rst === 1'b1) begin
      hi_cnt++;
      chk("in_reset", {8'h03, 24'h00_0000}, {run_en, pc_load, port_in, pc_val});
    end else if (nrst) begin
      chk("running", 32'h4, {run_en, pc_load, port_in});
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  // k1 for n cycles, then after g idle cycles one debug pulse
  task automatic run(input logic [2:0] k1, input int n, input int g);
    int exp;
    int l1;
    int f;
    int l;
    logic [2:0] cz;
    l1 = (k1 < 3) ? 2 : 0;
    f = 1 + l1;
    l = n + l1;
    if (k1 > 5) begin
      f = n + g + 1;
      l = f;
    end
    if (g > 0 && n + g + 1 > l) l = n + g + 1;
    exp = (k1 > 5 && g == 0) ? 0 : l + HOLD - f + 1;
    cz = (g > 0 && g + 1 > l1) ? 3'h5 : k1;
    @(posedge clk);
    kind <= k1;
    on <= 1'b1;
    hi_cnt = 0;
    repeat (n) @(posedge clk);
    on <= 1'b0;
    if (g > 0) begin
      repeat (g) @(posedge clk);
      kind <= 3'h5;
      on <= 1'b1;
      @(posedge clk);
      on <= 1'b0;
    end
    repeat (2 * HOLD + 16) @(posedge clk);
    chk("reset_len", 32'(exp), 32'(hi_cnt));
    if (exp > 0) begin
      chk("cause", 32'(cz), 32'(cause));
      chk("wdt_init", (cz == 3'h3) ? 32'h20 : 32'h0, 32'(wdt_init));
      chk("rtc_init", (cz == 3'h4) ? 32'h2 : 32'h0, 32'(rtc_init & 8'h43));
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h8067));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    hi_cnt = 0;
    repeat (2 * HOLD + 12) @(posedge clk);
    chk("init_len", 32'(3 + HOLD), 32'(hi_cnt));
    chk("init_cause", 32'h0, 32'(cause));
    for (int k = 0; k < 8; k++) begin
      run(3'(k), 1, 0);
      run(3'(k), 2, 1);
    end
    repeat (12) begin
      run(3'($urandom % 8), 1 + $urandom % 3, $urandom % 3);
    end
    print_verdict();
  end
endmodule
